// file: logic/dlytm_core.v
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`include "dlytm_defines.vh"
module dlytm_core #(
	parameter CLK_KHZ = 250000, // pclk in kHz
	parameter TW      = 32      // Count and preset width
) (
	input  wire          pclk,        // Clock
	input  wire          presetn,     // Async reset, low
	input  wire          psel,        // APB select
	input  wire          penable,     // APB enable
	input  wire          pwrite,      // APB direction
	input  wire [11:0]   paddr,       // APB byte address
	input  wire [31:0]   pwdata,      // APB write data
	output reg  [31:0]   prdata,      // APB read data
	output reg           pready,      // APB ready
	output reg           pslverr,     // APB error
	input  wire          trig_in,     // Trigger pin
	input  wire          rst_in,      // Reset pin
	input  wire          power_fail,  // Power loss pulse
	output reg  [7:0]    ref_blk,     // Block number being fetched
	input  wire [TW-1:0] ref_val,     // Live value of that block
	output reg           out_q        // Relay output
);
	reg [31:0] ctrl_q;
	reg [TW-1:0] high_delay_q;
	reg [TW-1:0] low_delay_q;
	reg [31:0] src_q;
	reg [TW-1:0] elapsed_count_q;
	reg [TW-1:0] ref_h_q;
	reg [TW-1:0] ref_l_q;
	reg          ref_phase_q;
	reg          run_q;
	reg          phase_q;
	reg          trg_m_q, trg_s_q, trg_p_q;
	reg          rst_m_q, rst_s_q;
	reg          pf_m_q, pf_s_q;
	wire         tick;
	wire [1:0]   mode = ctrl_q[`DLYTM_CTRL_MODE_MSB:`DLYTM_CTRL_MODE_LSB];
	wire [1:0]   tb   = ctrl_q[`DLYTM_CTRL_TB_MSB:`DLYTM_CTRL_TB_LSB];
	wire         rise = trg_s_q & ~trg_p_q;
	wire         fall = ~trg_s_q & trg_p_q;
	wire         trg  = trg_s_q;
	wire         rst  = rst_s_q;
	wire         sel_wr = psel & penable & pwrite & pready;
	wire         sel_rd = psel & ~penable & ~pwrite;
	wire         mode_wr = sel_wr & (paddr == `DLYTM_OFF_CTRL) &
	                       (pwdata[`DLYTM_CTRL_MODE_MSB:`DLYTM_CTRL_MODE_LSB] != mode);
	reg  [TW-1:0] ref_max;
	reg  [TW-1:0] h_pre, l_pre;
	reg  [TW-1:0] cnt_d;
	reg           run_d, out_d, phase_d;
	wire          h_hit = run_q & (elapsed_count_q >= h_pre);
	wire          l_hit = run_q & (elapsed_count_q >= l_pre);
	wire [TW-1:0] cnt_inc = elapsed_count_q + {{(TW-1){1'b0}}, tick};
	// Tick per selected timebase
	dlytm_tick #(
		.CLK_KHZ (CLK_KHZ),
		.CW      (40)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.tb      (tb),
		.tick_q  (tick)
	);
	always @* begin
		case (tb)
		`DLYTM_TB_SEC: ref_max = `DLYTM_MAX_REF_SEC;
		`DLYTM_TB_MIN: ref_max = `DLYTM_MAX_REF_MIN;
		default: ref_max = `DLYTM_MAX_REF_HOUR;
		endcase
	end
	// Preset source select; referenced values clamped
	always @* begin
		h_pre = ctrl_q[`DLYTM_CTRL_HSRC] ? ref_h_q : high_delay_q;
		l_pre = ctrl_q[`DLYTM_CTRL_LSRC] ? ref_l_q : low_delay_q;
	end
	// Alternate fetch of the two referenced blocks; value arrives next cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_phase_q <= 1'b0;
			ref_blk     <= 8'h00;
			ref_h_q     <= {TW{1'b0}};
			ref_l_q     <= {TW{1'b0}};
		end else begin
			ref_phase_q <= ~ref_phase_q;
			ref_blk <= ref_phase_q ? src_q[`DLYTM_SRC_HBLK_MSB:`DLYTM_SRC_HBLK_LSB]
			                       : src_q[`DLYTM_SRC_LBLK_MSB:`DLYTM_SRC_LBLK_LSB];
			if (ref_phase_q)
				ref_l_q <= (ref_val > ref_max) ? ref_max : ref_val;
			else
				ref_h_q <= (ref_val > ref_max) ? ref_max : ref_val;
		end
	end
	// Pin synchronisers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trg_m_q <= 1'b0;
			trg_s_q <= 1'b0;
			trg_p_q <= 1'b0;
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
			pf_m_q  <= 1'b0;
			pf_s_q  <= 1'b0;
		end else begin
			trg_m_q <= trig_in;
			trg_s_q <= trg_m_q;
			trg_p_q <= trg_s_q;
			rst_m_q <= rst_in;
			rst_s_q <= rst_m_q;
			pf_m_q  <= power_fail;
			pf_s_q  <= pf_m_q;
		end
	end
	// Timer behaviour per mode
	always @* begin
		cnt_d   = elapsed_count_q;
		run_d   = run_q;
		out_d   = out_q;
		phase_d = phase_q;
		case (mode)
		`DLYTM_MODE_ON: begin
			if (!trg) begin
				out_d = 1'b0;
				run_d = 1'b0;
				cnt_d = {TW{1'b0}};
			end else if (rise) begin
				run_d = 1'b1;
				cnt_d = {TW{1'b0}};
			end else if (h_hit) begin
				out_d = 1'b1;
				run_d = 1'b0;
			end else if (run_q) begin
				cnt_d = cnt_inc;
			end
		end
		`DLYTM_MODE_OFF: begin
			if (rst) begin
				out_d = 1'b0;
				run_d = 1'b0;
				cnt_d = {TW{1'b0}};
			end else if (trg) begin
				out_d = 1'b1;
				run_d = 1'b0;
				cnt_d = {TW{1'b0}};
			end else if (fall) begin
				run_d = 1'b1;
				cnt_d = {TW{1'b0}};
			end else if (h_hit) begin
				out_d = 1'b0;
				run_d = 1'b0;
			end else if (run_q) begin
				cnt_d = cnt_inc;
			end
		end
		`DLYTM_MODE_ONOFF: begin
			// phase_q high while timing the low delay
			if (rise | fall) begin
				run_d   = trg ? ~out_q : out_q;
				phase_d = fall;
				cnt_d   = {TW{1'b0}};
			end else if (!phase_q & h_hit) begin
				out_d = 1'b1;
				run_d = 1'b0;
			end else if (phase_q & l_hit) begin
				out_d = 1'b0;
				run_d = 1'b0;
			end else if (run_q) begin
				cnt_d = cnt_inc;
			end
		end
		default: begin
			if (rst) begin
				out_d = 1'b0;
				run_d = 1'b0;
				phase_d = 1'b0;
				cnt_d = {TW{1'b0}};
			end else if (rise & !phase_q) begin
				run_d   = 1'b1;
				phase_d = 1'b1;
				cnt_d   = {TW{1'b0}};
			end else if (h_hit) begin
				out_d = 1'b1;
				run_d = 1'b0;
			end else if (run_q) begin
				cnt_d = cnt_inc;
			end
		end
		endcase
	end
	// Timer state; power loss clears it unless retention is on
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			elapsed_count_q <= {TW{1'b0}};
			run_q   <= 1'b0;
			phase_q <= 1'b0;
			out_q   <= 1'b0;
		end else if (mode_wr) begin
			// Phase and count mean something else in the new mode
			elapsed_count_q <= {TW{1'b0}};
			run_q   <= 1'b0;
			phase_q <= 1'b0;
			out_q   <= 1'b0;
		end else if (pf_s_q & !ctrl_q[`DLYTM_CTRL_RETAIN]) begin
			elapsed_count_q <= {TW{1'b0}};
			run_q   <= 1'b0;
			phase_q <= 1'b0;
			out_q   <= 1'b0;
		end else if (pf_s_q) begin
			run_q <= run_q;
		end else begin
			elapsed_count_q <= cnt_d;
			run_q   <= run_d;
			phase_q <= phase_d;
			out_q   <= out_d;
		end
	end
	// APB slave: no wait states, reads registered in setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q       <= `DLYTM_CTRL_RESET;
			high_delay_q <= {TW{1'b0}};
			low_delay_q  <= {TW{1'b0}};
			src_q        <= 32'h0000_0000;
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel & ~penable) begin
				case (paddr)
				`DLYTM_OFF_CTRL, `DLYTM_OFF_HIGH, `DLYTM_OFF_LOW, `DLYTM_OFF_SRC,
				`DLYTM_OFF_STAT, `DLYTM_OFF_ELAP: pslverr <= 1'b0;
				default: pslverr <= 1'b1;
				endcase
			end
			if (sel_rd) begin
				case (paddr)
				`DLYTM_OFF_CTRL: prdata <= ctrl_q;
				`DLYTM_OFF_HIGH: prdata <= high_delay_q;
				`DLYTM_OFF_LOW:  prdata <= low_delay_q;
				`DLYTM_OFF_SRC:  prdata <= src_q;
				`DLYTM_OFF_STAT: prdata <= {29'h0, phase_q, run_q, out_q};
				`DLYTM_OFF_ELAP: prdata <= elapsed_count_q;
				default:         prdata <= 32'h0000_0000;
				endcase
			end
			if (sel_wr) begin
				case (paddr)
				`DLYTM_OFF_CTRL: ctrl_q <= pwdata & 32'h0000_0337;
				`DLYTM_OFF_HIGH: high_delay_q <= pwdata;
				`DLYTM_OFF_LOW:  low_delay_q <= pwdata;
				`DLYTM_OFF_SRC:  src_q <= pwdata & 32'h00ff_00ff;
				default: ctrl_q <= ctrl_q;
				endcase
			end
		end
	end
endmodule

// file: common/dlytm_defines.vh
`ifndef DLYTM_DEFINES_VH
`define DLYTM_DEFINES_VH
// Register byte offsets
`define DLYTM_OFF_CTRL      12'h000
`define DLYTM_OFF_HIGH      12'h004
`define DLYTM_OFF_LOW       12'h008
`define DLYTM_OFF_SRC       12'h00c
`define DLYTM_OFF_STAT      12'h010
`define DLYTM_OFF_ELAP      12'h014
`define DLYTM_OFF_CLR       12'h018
// Control fields
`define DLYTM_CTRL_MODE_LSB 0
`define DLYTM_CTRL_MODE_MSB 1
`define DLYTM_CTRL_RETAIN   2
`define DLYTM_CTRL_TB_LSB   4
`define DLYTM_CTRL_TB_MSB   5
`define DLYTM_CTRL_HSRC     8
`define DLYTM_CTRL_LSRC     9
// Source register fields: block numbers
`define DLYTM_SRC_HBLK_LSB  0
`define DLYTM_SRC_HBLK_MSB  7
`define DLYTM_SRC_LBLK_LSB  16
`define DLYTM_SRC_LBLK_MSB  23
// Modes
`define DLYTM_MODE_ON       2'h0
`define DLYTM_MODE_OFF      2'h1
`define DLYTM_MODE_ONOFF    2'h2
`define DLYTM_MODE_RETON    2'h3
// Timebase codes: fixed preset resolution
`define DLYTM_TB_SEC        2'h0
`define DLYTM_TB_MIN        2'h1
`define DLYTM_TB_HOUR       2'h2
// Tick periods
`define DLYTM_TICK_SEC_MS   10
`define DLYTM_TICK_MIN_MS   1000
`define DLYTM_TICK_HOUR_MS  60000
// Limits of referenced presets per timebase
`define DLYTM_MAX_REF_SEC   32'd9999
`define DLYTM_MAX_REF_MIN   32'd5999
`define DLYTM_MAX_REF_HOUR  32'd5999
`define DLYTM_CTRL_RESET    32'h0000_0000
`endif

// file: logic/dlytm_tick.v
`timescale 1ns/1ps
`include "dlytm_defines.vh"
// Divides pclk down to the tick of the selected timebase
module dlytm_tick #(
	parameter CLK_KHZ = 250000,
	parameter CW      = 40
) (
	input  wire       pclk,     // Clock
	input  wire       presetn,  // Async reset, low
	input  wire [1:0] tb,       // Timebase code
	output reg        tick_q    // One-cycle tick
);
	// Products formed at 64 bits, then cut to the counter width on purpose
	localparam [63:0]   DIV_SEC_W  = CLK_KHZ * 64'd1 * `DLYTM_TICK_SEC_MS;
	localparam [63:0]   DIV_MIN_W  = CLK_KHZ * 64'd1 * `DLYTM_TICK_MIN_MS;
	localparam [63:0]   DIV_HOUR_W = CLK_KHZ * 64'd1 * `DLYTM_TICK_HOUR_MS;
	localparam [CW-1:0] DIV_SEC    = DIV_SEC_W[CW-1:0];
	localparam [CW-1:0] DIV_MIN    = DIV_MIN_W[CW-1:0];
	localparam [CW-1:0] DIV_HOUR   = DIV_HOUR_W[CW-1:0];
	reg  [CW-1:0] cnt_q;
	reg  [CW-1:0] div;
	always @* begin
		case (tb)
		`DLYTM_TB_SEC: div = DIV_SEC;
		`DLYTM_TB_MIN: div = DIV_MIN;
		default: div = DIV_HOUR;
		endcase
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= {CW{1'b0}};
			tick_q <= 1'b0;
		end else if (cnt_q >= div - 1'b1) begin
			cnt_q  <= {CW{1'b0}};
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end
endmodule

// file: testbench/dlytm_asserts.sv
`timescale 1ns/1ps
module dlytm_asserts (
	input wire logic        pclk,       // Clock
	input wire logic        presetn,    // Reset, low
	input wire logic        psel,       // Select
	input wire logic        penable,    // Enable
	input wire logic        pwrite,     // Direction
	input wire logic [11:0] paddr,      // Address
	input wire logic [31:0] pwdata,     // Write data
	input wire logic [31:0] prdata,     // Read data
	input wire logic        pready,     // Ready
	input wire logic        pslverr,    // Error
	input wire logic        trig_in,    // Trigger
	input wire logic        rst_in,     // Reset pin
	input wire logic        power_fail, // Power loss
	input wire logic        out_q       // Output
);
	logic [1:0] mode_q;
	// Mode seen only through completed writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_q <= 2'h0;
		else if (psel && penable && pready && pwrite && paddr == 12'h000)
			mode_q <= pwdata[1:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	a_ready_next: assert property (s_setup |=> pready)
		else $error("ready missing after setup");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_unmapped: assert property ((s_setup and paddr == 12'h018) |=> pready && pslverr)
		else $error("unmapped access not refused");
	a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_on_low: assert property ((mode_q == 2'h0 && !trig_in)[*5] |-> !out_q)
		else $error("on mode output high with trigger low");
	a_off_set: assert property ((mode_q == 2'h1 && trig_in && !rst_in && !power_fail)[*5] |-> out_q)
		else $error("off mode output not following trigger");
	a_ret_clear: assert property ((mode_q == 2'h3 && rst_in)[*5] |-> !out_q)
		else $error("retentive output kept under reset");
	a_ret_hold: assert property ((mode_q == 2'h3 && !rst_in && !power_fail)[*5] ##0 out_q |=> out_q)
		else $error("retentive output lost without reset");
endmodule

// file: testbench/dlytm_blocks.sv
`timescale 1ns/1ps
module dlytm_blocks (
	input  wire logic [7:0]  ref_blk, // Block asked for
	output logic      [31:0] ref_val  // Its live value
);
	// Block 8'hff reads far above any valid preset
	assign ref_val = (ref_blk == 8'hff) ? 32'hffff_ffff : {24'h0, ref_blk};
endmodule

// file: testbench/delay_timer_functions_test.sv
`timescale 1ns/1ps
module delay_timer_functions_test;
	logic        pclk, presetn, psel, penable, pwrite, trig_in, rst_in, power_fail;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, ref_val, rd;
	logic [7:0]  ref_blk;
	logic        pready, pslverr, out_q, err;
	int          fails, total_checks;
	dlytm_core #(.CLK_KHZ(1)) u_dlytm_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trig_in(trig_in), .rst_in(rst_in),
		.power_fail(power_fail), .ref_blk(ref_blk), .ref_val(ref_val), .out_q(out_q));
	dlytm_blocks u_dlytm_blocks (.ref_blk(ref_blk), .ref_val(ref_val));
	initial begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		// Only the watchdog ends a wait for ready
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Pins take three cycles to reach the output, so waits allow for that
	task automatic wait_out(input logic e, input int n);
		int k = 0;
		while (out_q !== e && k < n) begin
			k++;
			@(posedge pclk);
		end
		chk({31'h0, out_q}, {31'h0, e});
	endtask
	task automatic test_done;
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#80000;
		fails++;
		test_done;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = 0;
		{trig_in, rst_in, power_fail, presetn} = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, 12'h000, 0); chk(rd, 32'h0); chk({31'h0, err}, 32'h0);
		apb(0, 12'h018, 0); chk({31'h0, err}, 32'h1); chk(rd, 32'h0);
		apb(1, 12'h004, 32'h3); apb(0, 12'h004, 0); chk(rd, 32'h3);
		trig_in <= 1; cyc(15); wait_out(0, 0);
		wait_out(1, 40);
		trig_in <= 0; wait_out(0, 5);
		trig_in <= 1; cyc(20); trig_in <= 0; cyc(5);
		apb(0, 12'h014, 0); chk(rd, 32'h0);
		trig_in <= 1; cyc(18); wait_out(0, 0);
		wait_out(1, 40); trig_in <= 0; cyc(5);
		apb(1, 12'h000, 32'h1);
		trig_in <= 1; wait_out(1, 4);
		trig_in <= 0; cyc(15); trig_in <= 1; cyc(2); trig_in <= 0;
		cyc(18); wait_out(1, 0);
		wait_out(0, 25);
		trig_in <= 1; cyc(3); trig_in <= 0; cyc(5);
		rst_in <= 1; wait_out(0, 5);
		apb(0, 12'h014, 0); chk(rd, 32'h0);
		rst_in <= 0;
		apb(1, 12'h00c, 32'h0002_0000); apb(1, 12'h000, 32'h202);
		trig_in <= 1; cyc(15); wait_out(0, 0);
		wait_out(1, 40);
		trig_in <= 0; cyc(8); wait_out(1, 0);
		trig_in <= 1; cyc(30); wait_out(1, 0);
		trig_in <= 0; wait_out(0, 35);
		trig_in <= 1; cyc(15); trig_in <= 0; cyc(40); wait_out(0, 0);
		apb(1, 12'h000, 32'h7);
		trig_in <= 1; cyc(3); trig_in <= 0; wait_out(1, 45);
		trig_in <= 1; cyc(5); trig_in <= 0;
		power_fail <= 1; cyc(3); power_fail <= 0; cyc(5); wait_out(1, 0);
		apb(0, 12'h010, 0); chk(rd, 32'h5);
		rst_in <= 1; wait_out(0, 6);
		apb(0, 12'h014, 0); chk(rd, 32'h0);
		rst_in <= 0; cyc(3);
		trig_in <= 1; cyc(3); trig_in <= 0; wait_out(1, 45);
		apb(1, 12'h000, 32'h3);
		power_fail <= 1; cyc(3); power_fail <= 0; wait_out(0, 6);
		apb(0, 12'h014, 0); chk(rd, 32'h0);
		test_done;
	end
endmodule
bind dlytm_core dlytm_asserts u_dlytm_asserts (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .trig_in, .rst_in, .power_fail, .out_q);
